// *** design/ppc_pkg.sv ***
// Purpose: shared constants and carrier types of the parallel port pin control block
// Assumes: ports A, B and E of eight pins each, registers on an AXI4-Lite slave
// Notes:   byte address = port * 0x20 + register index * 4
`default_nettype none
package ppc_pkg;
    localparam int NPORT = 3;
    localparam int PW    = 8;
    localparam int NPIN  = NPORT * PW;

    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_E = 2;

    // address decode
    localparam int AXI_AW        = 7;
    localparam int ADDR_PORT_LSB = 5;
    localparam int ADDR_REG_LSB  = 2;

    // register index inside a port window
    localparam logic [2:0] REG_DATA       = 3'h0;
    localparam logic [2:0] REG_DIR        = 3'h1;
    localparam logic [2:0] REG_PULL       = 3'h2;
    localparam logic [2:0] REG_SLEW       = 3'h3;
    localparam logic [2:0] REG_DRIVE      = 3'h4;
    localparam logic [2:0] REG_IRQ_SC     = 3'h5;
    localparam logic [2:0] REG_IRQ_PINSEL = 3'h6;
    localparam logic [2:0] REG_IRQ_EDGE   = 3'h7;

    // pin_irq_status_control fields
    localparam int SC_MODE_BIT = 0;
    localparam int SC_IE_BIT   = 1;
    localparam int SC_ACK_BIT  = 2;
    localparam int SC_FLAG_BIT = 3;

    localparam logic [PW-1:0] RST_BYTE  = 8'h00;
    localparam logic [1:0]    RESP_OKAY = 2'h0;
    localparam logic [1:0]    RESP_ERR  = 2'h2;

    // pad side controls, one bit per pin, pin = port * PW + bit
    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] ie;
        logic [NPIN-1:0] pull_en;
        logic [NPIN-1:0] pull_dn;
        logic [NPIN-1:0] slew_en;
        logic [NPIN-1:0] drive_hi;
    } ppc_pads_t;

    // shared peripheral requests, one bit per pin
    typedef struct packed {
        logic [NPIN-1:0] dig_en;
        logic [NPIN-1:0] dig_out;
        logic [NPIN-1:0] dig_oe;
        logic [NPIN-1:0] ana_en;
    } ppc_periph_t;
endpackage : ppc_pkg
`default_nettype wire

// *** design/ppc_sync.sv ***
// Purpose: two flip-flop synchroniser for a vector of pad levels
// Assumes: each bit changes independently, no word coherence needed
// Notes:   only the second stage may be read by other logic
`default_nettype none
`timescale 1ns/1ps
module ppc_sync #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : ppc_sync
`default_nettype wire

// *** design/ppc_pin_cell.sv ***
// Purpose: buffer, pull, slew and drive control of one pin plus its data read bit
// Assumes: purely combinational, the top registers every output
// Notes:   analog ownership outranks digital ownership, which outranks gpio
`default_nettype none
`timescale 1ns/1ps
module ppc_pin_cell (
    // gpio settings
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pull,
    input  wire logic slew,
    input  wire logic drive,
    input  wire logic pd_sel,
    // pin kind
    input  wire logic in_only,
    input  wire logic out_only,
    // shared functions
    input  wire logic dig_en,
    input  wire logic dig_out,
    input  wire logic dig_oe,
    input  wire logic ana_en,
    // synchronised pad level
    input  wire logic pin_in,
    // results
    output logic      pad_out,
    output logic      pad_oe,
    output logic      pad_ie,
    output logic      pad_pull_en,
    output logic      pad_pull_dn,
    output logic      pad_slew,
    output logic      pad_drive,
    output logic      rd_bit
);
    always_comb begin
        if (ana_en) begin
            pad_oe = 1'b0;
        end else if (dig_en) begin
            pad_oe = dig_oe & ~in_only;
        end else begin
            pad_oe = dir & ~in_only;
        end
        pad_out     = dig_en ? dig_out : latch;
        pad_ie      = ~ana_en & ~out_only;
        pad_pull_en = pull & ~dir & ~pad_oe & ~ana_en;
        pad_pull_dn = pad_pull_en & pd_sel;
        pad_slew    = slew & pad_oe;
        // input-only pin keeps its drive bit but never drives
        pad_drive   = drive & pad_oe & ~in_only;
        // read source follows the direction bit even under a peripheral
        if (dir) begin
            rd_bit = latch;
        end else begin
            rd_bit = pad_ie & pin_in;
        end
    end
endmodule : ppc_pin_cell
`default_nettype wire

// *** design/ppc_top.sv ***
// Purpose: parallel port pin control for ports A, B and E with a port B pin interrupt
// Assumes: AXI4-Lite register access, pad inputs asynchronous to clk_sys
// Notes:   all pad controls and bus outputs come from flip-flops
// Function
// - direction bit enables output and picks read source
// - input buffer on unless analog or output-only
// - digital peripheral drives buffer; direction picks read
// - analog function disables input and output buffers
// - input with disabled input buffer reads zero
// - pull enable per pin, off for outputs
// - pull-down only for selected interrupt pins
// - slew enable per pin, only for outputs
// - drive strength low or high, outputs only
// - input-only pin drive bit writable, no effect
// - interrupt flag at bit 3, writes ignored
// - write one to acknowledge bit 2 clears flag
// - interrupt request only when enabled and flagged
// - mode bit 0 selects edges or edges plus levels
// - reset: peripherals off, inputs, low drive, no pulls
// - enabled peripheral overrides gpio on shared pin
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
`timescale 1ns/1ps
module ppc_top
    import ppc_pkg::*;
#(
    parameter logic [ppc_pkg::NPIN-1:0] IN_ONLY_MASK  = 24'h020000,
    parameter logic [ppc_pkg::NPIN-1:0] OUT_ONLY_MASK = 24'h000000
) (
    // clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    // axi4-lite write address
    input  wire logic [ppc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // axi4-lite read address
    input  wire logic [ppc_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // pads
    input  wire logic [ppc_pkg::NPIN-1:0] pad_in,
    output ppc_pkg::ppc_pads_t            pads,
    // shared peripherals
    input  wire ppc_pkg::ppc_periph_t     periph,
    // port b pin interrupt
    output logic                          pin_irq
);
    generate
        if (NPORT != 3 || PW != 8) begin
            $error("ppc_top: register map needs three ports of eight pins");
        end
        if ((IN_ONLY_MASK & OUT_ONLY_MASK) != '0) begin
            $error("ppc_top: a pin cannot be input-only and output-only");
        end
    endgenerate

    // software state
    logic [NPORT-1:0][PW-1:0] data_latch, next_data_latch;
    logic [NPORT-1:0][PW-1:0] pin_direction_bit, next_pin_direction_bit;
    logic [NPORT-1:0][PW-1:0] pull_enable_bits, next_pull_enable_bits;
    logic [NPORT-1:0][PW-1:0] slew_enable_bits, next_slew_enable_bits;
    logic [NPORT-1:0][PW-1:0] drive_select_bits, next_drive_select_bits;
    logic [PW-1:0]            irq_pin_select, next_irq_pin_select;
    logic [PW-1:0]            edge_polarity_select, next_edge_polarity_select;
    logic                     pin_irq_flag, next_pin_irq_flag;
    logic                     pin_irq_enable, next_pin_irq_enable;
    logic                     detect_mode_select, next_detect_mode_select;

    // bus state
    logic                     aw_full, next_aw_full;
    logic                     w_full, next_w_full;
    logic [AXI_AW-1:0]        aw_addr, next_aw_addr;
    logic [31:0]              w_data, next_w_data;
    logic [3:0]               w_strb, next_w_strb;
    logic                     next_awready, next_wready, next_arready;
    logic                     next_bvalid, next_rvalid;
    logic [1:0]               next_bresp, next_rresp;
    logic [31:0]              next_rdata;

    // interrupt detect state
    logic [PW-1:0]            prev_active, next_prev_active;
    logic                     next_pin_irq;

    // pin cell results
    logic [NPIN-1:0]          pin_sync;
    logic [NPIN-1:0]          rd_bits;
    ppc_pads_t                next_pads;

    // decode helpers
    logic                     do_write, ack_pulse;
    logic [1:0]               w_port, r_port;
    logic [2:0]               w_reg, r_reg;
    logic                     w_hit, r_hit;
    logic [PW-1:0]            w_byte, rd_byte;
    logic [PW-1:0]            b_active, b_edge, b_level;
    logic                     irq_event;

    // asynchronous pads never reach logic directly
    ppc_sync #(
        .WIDTH (NPIN)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d       (pad_in),
        .q       (pin_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            localparam int P = gi / PW;
            localparam int B = gi % PW;
            ppc_pin_cell u_cell (
                .dir         (pin_direction_bit[P][B]),
                .latch       (data_latch[P][B]),
                .pull        (pull_enable_bits[P][B]),
                .slew        (slew_enable_bits[P][B]),
                .drive       (drive_select_bits[P][B]),
                .pd_sel      ((P == PORT_B) ? (irq_pin_select[B] &
                              edge_polarity_select[B]) : 1'b0),
                .in_only     (IN_ONLY_MASK[gi]),
                .out_only    (OUT_ONLY_MASK[gi]),
                .dig_en      (periph.dig_en[gi]),
                .dig_out     (periph.dig_out[gi]),
                .dig_oe      (periph.dig_oe[gi]),
                .ana_en      (periph.ana_en[gi]),
                .pin_in      (pin_sync[gi]),
                .pad_out     (next_pads.out[gi]),
                .pad_oe      (next_pads.oe[gi]),
                .pad_ie      (next_pads.ie[gi]),
                .pad_pull_en (next_pads.pull_en[gi]),
                .pad_pull_dn (next_pads.pull_dn[gi]),
                .pad_slew    (next_pads.slew_en[gi]),
                .pad_drive   (next_pads.drive_hi[gi]),
                .rd_bit      (rd_bits[gi])
            );
        end
    endgenerate

    // address decode
    always_comb begin
        do_write = aw_full & w_full & ~s_axi_bvalid;
        w_port   = aw_addr[ADDR_PORT_LSB +: 2];
        w_reg    = aw_addr[ADDR_REG_LSB +: 3];
        w_hit    = (w_port == 2'(PORT_B)) ||
                   ((w_port < 2'(NPORT)) && (w_reg <= REG_DRIVE));
        w_byte   = w_data[PW-1:0];
        r_port   = s_axi_araddr[ADDR_PORT_LSB +: 2];
        r_reg    = s_axi_araddr[ADDR_REG_LSB +: 3];
        r_hit    = (r_port == 2'(PORT_B)) ||
                   ((r_port < 2'(NPORT)) && (r_reg <= REG_DRIVE));
        ack_pulse = do_write & w_hit & w_strb[0] & (w_port == 2'(PORT_B)) &
                    (w_reg == REG_IRQ_SC) & w_byte[SC_ACK_BIT];
    end

    // port b interrupt detection on synchronised levels
    always_comb begin
        // edge select 1 means rising edge or high level
        b_active  = ~(pin_sync[PORT_B*PW +: PW] ^ edge_polarity_select);
        b_edge    = b_active & ~prev_active;
        b_level   = detect_mode_select ? b_active : '0;
        irq_event = |(irq_pin_select & (b_edge | b_level));
        next_prev_active = b_active;
        // a fresh event wins over the acknowledge of the same cycle
        next_pin_irq_flag = irq_event | (pin_irq_flag & ~ack_pulse);
        next_pin_irq      = next_pin_irq_flag & next_pin_irq_enable;
    end

    // register writes
    always_comb begin
        next_data_latch           = data_latch;
        next_pin_direction_bit    = pin_direction_bit;
        next_pull_enable_bits     = pull_enable_bits;
        next_slew_enable_bits     = slew_enable_bits;
        next_drive_select_bits    = drive_select_bits;
        next_irq_pin_select       = irq_pin_select;
        next_edge_polarity_select = edge_polarity_select;
        next_pin_irq_enable       = pin_irq_enable;
        next_detect_mode_select   = detect_mode_select;
        if (do_write && w_hit && w_strb[0]) begin
            case (w_reg)
                REG_DATA:       next_data_latch[w_port] = w_byte;
                REG_DIR:        next_pin_direction_bit[w_port] = w_byte;
                REG_PULL:       next_pull_enable_bits[w_port] = w_byte;
                REG_SLEW:       next_slew_enable_bits[w_port] = w_byte;
                REG_DRIVE:      next_drive_select_bits[w_port] = w_byte;
                REG_IRQ_SC: begin
                    next_pin_irq_enable     = w_byte[SC_IE_BIT];
                    next_detect_mode_select = w_byte[SC_MODE_BIT];
                end
                REG_IRQ_PINSEL: next_irq_pin_select = w_byte;
                REG_IRQ_EDGE:   next_edge_polarity_select = w_byte;
                default:        next_data_latch = data_latch;
            endcase
        end
    end

    // read mux
    always_comb begin
        rd_byte = '0;
        case (r_reg)
            REG_DATA:       rd_byte = rd_bits[r_port*PW +: PW];
            REG_DIR:        rd_byte = pin_direction_bit[r_port];
            REG_PULL:       rd_byte = pull_enable_bits[r_port];
            REG_SLEW:       rd_byte = slew_enable_bits[r_port];
            REG_DRIVE:      rd_byte = drive_select_bits[r_port];
            REG_IRQ_SC: begin
                rd_byte[SC_FLAG_BIT] = pin_irq_flag;
                rd_byte[SC_IE_BIT]   = pin_irq_enable;
                rd_byte[SC_MODE_BIT] = detect_mode_select;
            end
            REG_IRQ_PINSEL: rd_byte = irq_pin_select;
            REG_IRQ_EDGE:   rd_byte = edge_polarity_select;
            default:        rd_byte = '0;
        endcase
        if (!r_hit) begin
            rd_byte = '0;
        end
    end

    // axi4-lite handshakes
    always_comb begin
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = w_hit ? RESP_OKAY : RESP_ERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = r_hit ? RESP_OKAY : RESP_ERR;
            next_rdata  = {24'h000000, rd_byte};
        end
        // one write and one read in flight at a time
        next_awready = ~next_aw_full & ~next_bvalid;
        next_wready  = ~next_w_full & ~next_bvalid;
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            data_latch           <= '0;
            pin_direction_bit    <= '0;
            pull_enable_bits     <= '0;
            slew_enable_bits     <= '0;
            drive_select_bits    <= '0;
            irq_pin_select       <= RST_BYTE;
            edge_polarity_select <= RST_BYTE;
            pin_irq_flag         <= 1'b0;
            pin_irq_enable       <= 1'b0;
            detect_mode_select   <= 1'b0;
            prev_active          <= RST_BYTE;
            pin_irq              <= 1'b0;
            pads                 <= '0;
            aw_full              <= 1'b0;
            w_full               <= 1'b0;
            aw_addr              <= '0;
            w_data               <= '0;
            w_strb               <= '0;
            s_axi_awready        <= 1'b0;
            s_axi_wready         <= 1'b0;
            s_axi_arready        <= 1'b0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= RESP_OKAY;
            s_axi_rvalid         <= 1'b0;
            s_axi_rresp          <= RESP_OKAY;
            s_axi_rdata          <= '0;
        end else begin
            data_latch           <= next_data_latch;
            pin_direction_bit    <= next_pin_direction_bit;
            pull_enable_bits     <= next_pull_enable_bits;
            slew_enable_bits     <= next_slew_enable_bits;
            drive_select_bits    <= next_drive_select_bits;
            irq_pin_select       <= next_irq_pin_select;
            edge_polarity_select <= next_edge_polarity_select;
            pin_irq_flag         <= next_pin_irq_flag;
            pin_irq_enable       <= next_pin_irq_enable;
            detect_mode_select   <= next_detect_mode_select;
            prev_active          <= next_prev_active;
            pin_irq              <= next_pin_irq;
            pads                 <= next_pads;
            aw_full              <= next_aw_full;
            w_full               <= next_w_full;
            aw_addr              <= next_aw_addr;
            w_data               <= next_w_data;
            w_strb               <= next_w_strb;
            s_axi_awready        <= next_awready;
            s_axi_wready         <= next_wready;
            s_axi_arready        <= next_arready;
            s_axi_bvalid         <= next_bvalid;
            s_axi_bresp          <= next_bresp;
            s_axi_rvalid         <= next_rvalid;
            s_axi_rresp          <= next_rresp;
            s_axi_rdata          <= next_rdata;
        end
    end
endmodule : ppc_top
`default_nettype wire

// *** tb/ppc_pad_model.sv ***
// Purpose: pad ring outside the block: bench drive, pulls, floating pins
// Assumes: block drive wins wherever oe is high
// Notes:   an undriven pin without pull toggles every cycle
`default_nettype none
`timescale 1ns/1ps
module ppc_pad_model
    import ppc_pkg::*;
(
    // clock
    input  wire logic                     clk_sys,
    // block side
    input  wire ppc_pkg::ppc_pads_t       pads,
    output logic [ppc_pkg::NPIN-1:0]      pad_in,
    // bench side
    input  wire logic [ppc_pkg::NPIN-1:0] ext_en,
    input  wire logic [ppc_pkg::NPIN-1:0] ext_lvl
);
    logic [NPIN-1:0] flt = '0;
    logic [NPIN-1:0] idle;
    // a float never settles, so no read may lean on it
    always @(posedge clk_sys) flt <= ~flt;
    assign idle   = (pads.pull_en & ~pads.pull_dn) | (~pads.pull_en & flt);
    assign pad_in = (pads.oe & pads.out) | (~pads.oe & ((ext_en & ext_lvl) | (~ext_en & idle)));
endmodule : ppc_pad_model
`default_nettype wire

// *** tb/ppc_top_props.sv ***
// Purpose: port checks of the pin control block
// Assumes: pad controls are registered one cycle after their causes
// Notes:   bound into ppc_top from the bench
`default_nettype none
`timescale 1ns/1ps
module ppc_top_props
    import ppc_pkg::*;
#(
    parameter logic [ppc_pkg::NPIN-1:0] IN_ONLY_MASK  = 24'h020000,
    parameter logic [ppc_pkg::NPIN-1:0] OUT_ONLY_MASK = 24'h000000
) (
    input wire logic                 clk_sys,
    input wire logic                 resetn,
    input wire ppc_pkg::ppc_pads_t   pads,
    input wire ppc_pkg::ppc_periph_t periph,
    input wire logic                 pin_irq,
    input wire logic                 s_axi_bvalid,
    input wire logic [1:0]           s_axi_bresp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_ana; $past(resetn) |-> ((pads.ie | pads.oe) & $past(periph.ana_en)) == 24'h0;
    endproperty
    a_ana: assert property (p_ana) else $error("analog pin buffer on");
    property p_dig; $past(resetn) |-> ((pads.oe ^ $past(periph.dig_oe))
        & $past(periph.dig_en & ~periph.ana_en) & ~IN_ONLY_MASK) == 24'h0; endproperty
    a_dig: assert property (p_dig) else $error("peripheral oe not followed");
    property p_ie; $past(resetn) |-> pads.ie == (~$past(periph.ana_en) & ~OUT_ONLY_MASK);
    endproperty
    a_ie: assert property (p_ie) else $error("input buffer wrong");
    property p_pull; (pads.pull_en & pads.oe) == 24'h0; endproperty
    a_pull: assert property (p_pull) else $error("pull on driven pin");
    property p_slew; (pads.slew_en & ~pads.oe) == 24'h0; endproperty
    a_slew: assert property (p_slew) else $error("slew on input pin");
    property p_drv; (pads.drive_hi & ~pads.oe) == 24'h0; endproperty
    a_drv: assert property (p_drv) else $error("drive on input pin");
    property p_inonly; ((pads.oe | pads.drive_hi) & IN_ONLY_MASK) == 24'h0; endproperty
    a_inonly: assert property (p_inonly) else $error("input-only pin driven");
    property p_pdn; (pads.pull_dn & ~24'h00FF00) == 24'h0; endproperty
    a_pdn: assert property (p_pdn) else $error("pull-down off irq port");
    property p_rst; disable iff (1'b0) !resetn |=> pads == '0 && !pin_irq; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_irq: cover property ($rose(pin_irq));
    c_ana: cover property (periph.ana_en != 24'h0);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_ERR);
endmodule : ppc_top_props
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: register level bench of the pin control block
// Assumes: one axi4-lite master, pins answered by the pad model
// Notes:   expected read values follow the bench pin pattern
`default_nettype none
`timescale 1ns/1ps
module tb;
    import ppc_pkg::*;
    logic clk_sys = 0, resetn = 0;
    logic [6:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata;
    logic awready, wready, bvalid, arready, rvalid, pin_irq;
    logic [1:0] bresp, rresp;
    logic [NPIN-1:0] pad_in, ext_en = '1, ext_lvl = 24'h5A5A5A;
    ppc_pads_t pads;
    ppc_periph_t periph = '0;
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    ppc_top u_ppc_top (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pad_in(pad_in), .pads(pads), .periph(periph),
        .pin_irq(pin_irq));
    ppc_pad_model u_ppc_pad_model (.clk_sys(clk_sys), .pads(pads), .pad_in(pad_in),
        .ext_en(ext_en), .ext_lvl(ext_lvl));
    task automatic tally_and_finish();
        if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // ready is read at the falling edge, the value the next rising edge samples
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic ta, tw, tb_;
        logic [1:0] r;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge clk_sys);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb_ = bvalid === 1'b1;
            r = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end while (!tb_);
        bready <= 0;
        chk({30'h0, r}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
        logic ta, tr;
        logic [33:0] got;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge clk_sys);
            ta = arvalid & arready;
            tr = rvalid === 1'b1;
            got = {rresp, rdata};
            @(posedge clk_sys);
            if (ta) arvalid <= 0;
        end while (!tr);
        rready <= 0;
        chk(got[31:0], {24'h0, e});
        chk({30'h0, got[33:32]}, {30'h0, er});
    endtask : rd
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1;
        repeat (3) @(negedge clk_sys);
        chk(pads.ie, 24'hFFFFFF);
        chk(pads.oe | pads.pull_en | pads.drive_hi | pads.slew_en, 24'h0);
        for (int p = 0; p < 3; p++) begin
            rd(7'(p * 32), ext_lvl[p*8 +: 8]);
            for (int i = 1; i < 5; i++) rd(7'(p * 32 + i * 4), 8'h00);
        end
        for (int i = 5; i < 8; i++) rd(7'(32 + i * 4), 8'h00);
        wr(7'h04, 8'hF0);
        wr(7'h00, 8'hA5);
        @(negedge clk_sys);
        chk(pads.oe[7:0], 8'hF0);
        chk(pads.out[7:4], 4'hA);
        rd(7'h00, 8'hAA);
        wr(7'h08, 8'hFF);
        wr(7'h0C, 8'hFF);
        wr(7'h10, 8'hFF);
        ext_en <= 24'hFFFFFB;
        repeat (4) @(negedge clk_sys);
        chk(pads.pull_en[7:0], 8'h0F);
        chk(pads.slew_en[7:0], 8'hF0);
        chk(pads.drive_hi[7:0], 8'hF0);
        rd(7'h00, 8'hAE);
        rd(7'h10, 8'hFF);
        wr(7'h44, 8'hFF);
        wr(7'h50, 8'hFF);
        @(negedge clk_sys);
        chk(pads.drive_hi[23:16], 8'hFD);
        rd(7'h50, 8'hFF);
        periph.ana_en <= 24'h000022;
        periph.dig_en <= 24'h000010;
        repeat (4) @(negedge clk_sys);
        chk(pads.oe[7:0], 8'hC0);
        chk(pads.ie[7:0], 8'hDD);
        rd(7'h00, 8'hAC);
        periph <= '0;
        wr(7'h38, 8'h01);
        wr(7'h3C, 8'h01);
        wr(7'h28, 8'h01);
        @(negedge clk_sys);
        chk(pads.pull_dn[15:8], 8'h01);
        wr(7'h34, 8'h02);
        ext_lvl[8] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(7'h34, 8'h0A);
        chk(pin_irq, 1'b1);
        wr(7'h34, 8'h08);
        rd(7'h34, 8'h08);
        chk(pin_irq, 1'b0);
        wr(7'h34, 8'h04);
        rd(7'h34, 8'h00);
        wr(7'h34, 8'h01);
        rd(7'h34, 8'h09);
        wr(7'h34, 8'h05);
        rd(7'h34, 8'h09);
        ext_lvl[8] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr(7'h34, 8'h05);
        rd(7'h34, 8'h01);
        wr(7'h60, 8'hFF, RESP_ERR);
        rd(7'h60, 8'h00, RESP_ERR);
        rd(7'h14, 8'h00, RESP_ERR);
        tally_and_finish();
    end
endmodule : tb
bind ppc_top ppc_top_props #(.IN_ONLY_MASK(IN_ONLY_MASK), .OUT_ONLY_MASK(OUT_ONLY_MASK))
    u_ppc_top_props (.clk_sys, .resetn, .pads, .periph, .pin_irq, .s_axi_bvalid, .s_axi_bresp);
`default_nettype wire
